/* pkg/lp_clock_pkg.sv */
// Overview of operation
// R1: six main-oscillator processor/peripheral clock modes
// R2: doubler halves every selected divider; the 32 kHz divider is not halved
// R3: 32 kHz clock undivided or /2,/4,/8,/16
// R4: short selects only below full speed
// R5: separate short-select enables for reads, writes
// R6: short select two oscillator clocks, at end
// R7: read data captured at second-state end
// R8: wait states go between the two states
// R9: 32 kHz short select lasts one period
// R10: self-timed select asserts for chosen short time
// R11: reset/watchdog status field, cleared by read
// R12: force bit pends periodic interrupt, reads zero
// R13: periodic interrupt priority field, 00 disables
// R14: clock-select field chooses the clock mode
// R15: 32 kHz divider field codes 000, 100-111
// R16: power-save read bit selects short reads
// R17: power-save write bit selects short writes
// R18: self-timed width field, 296 to 109 ns
// R19: mode changes never glitch clock enables
package lp_clock_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_GLOBAL_CONTROL_STATUS = 8'h00;
    localparam logic [7:0] IDX_POWER_SAVE_CONTROL = 8'h0D;
    localparam logic [7:0] IDX_CLOCK_DOUBLER = 8'h0F;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h11;
    // global_control_status fields
    localparam int GCS_STAT_LSB = 6;
    localparam int GCS_FORCE_BIT = 5;
    localparam int GCS_SEL_LSB = 2;
    localparam int GCS_PRIO_LSB = 0;
    localparam logic [1:0] STAT_NONE = 2'h0;
    localparam logic [1:0] STAT_WATCHDOG = 2'h1;
    localparam logic [1:0] STAT_RESET = 2'h3;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [1:0] PRIO_RESET = 2'h0;
    // clock-select codes
    localparam logic [2:0] SEL_CPU8_PER8 = 3'h0;
    localparam logic [2:0] SEL_CPU8_PER1 = 3'h1;
    localparam logic [2:0] SEL_FULL = 3'h2;
    localparam logic [2:0] SEL_DIV2 = 3'h3;
    localparam logic [2:0] SEL_SLOW_OSC_ON = 3'h4;
    localparam logic [2:0] SEL_SLOW_OSC_OFF = 3'h5;
    localparam logic [2:0] SEL_DIV4 = 3'h6;
    localparam logic [2:0] SEL_DIV6 = 3'h7;
    // power_save_control fields
    localparam int PSC_SELFT_LSB = 5;
    localparam int PSC_SHORT_RD_BIT = 4;
    localparam int PSC_SHORT_WR_BIT = 3;
    localparam int PSC_DIV32_LSB = 0;
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam logic [3:0] DBL_RESET = 4'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // interrupt status bits
    localparam int IRQ_WATCHDOG = 0;
    localparam int IRQ_PERIODIC = 1;
    localparam int IRQ_BUS_DONE = 2;
    // timing: the clock runs at twice the main oscillator
    localparam int CLK_MHZ = 40;
    localparam int CLKS_PER_OSC = 2;
    localparam int SHORT_CS_OSC_CLOCKS = 2;
    localparam logic [4:0] SHORT_CS_TICKS = 5'(SHORT_CS_OSC_CLOCKS * CLKS_PER_OSC);
    localparam logic [4:0] SLOW_CS_TICKS = 5'h01;
    localparam int SELFT_NS_100 = 296;
    localparam int SELFT_NS_101 = 234;
    localparam int SELFT_NS_110 = 171;
    localparam int SELFT_NS_111 = 109;
    localparam logic [3:0] SELFT_CYC_100 = 4'((SELFT_NS_100 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] SELFT_CYC_101 = 4'((SELFT_NS_101 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] SELFT_CYC_110 = 4'((SELFT_NS_110 * CLK_MHZ + 999) / 1000);
    localparam logic [3:0] SELFT_CYC_111 = 4'((SELFT_NS_111 * CLK_MHZ + 999) / 1000);
    // bus transaction states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FIRST = 4'h2,
        ST_WAIT = 4'h4,
        ST_SECOND = 4'h8
    } bus_state_t;
endpackage

/* rtl/clk_period_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module clk_period_divider
    import lp_clock_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // source ticks and divisor
    input wire logic i_tick,
    input wire logic [4:0] i_div,
    // period outputs
    output logic o_pulse,
    output logic [4:0] o_left
);
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;

    // a new divisor is taken only when a period ends [R19]
    always_comb begin
        cnt_next = cnt_reg;
        if (i_tick) begin
            if (cnt_reg <= 5'h01) begin
                cnt_next = (i_div == 5'h00) ? 5'h01 : i_div;
            end else begin
                cnt_next = cnt_reg - 5'h01;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= 5'h01;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign o_pulse = i_tick && (cnt_reg <= 5'h01);
    assign o_left = cnt_reg;
endmodule
`default_nettype wire

/* rtl/lp_clock_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module lp_clock_ctrl
    import lp_clock_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // ahb-lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // slow clock and system events
    input wire logic I_CLK32K,
    input wire logic I_WDT_TIMEOUT,
    input wire logic I_PERIODIC_TICK,
    input wire logic I_PERIODIC_ACK,
    // processor bus requests
    input wire logic I_BUS_REQ,
    input wire logic I_BUS_WRITE,
    input wire logic I_BUS_WAIT,
    input wire logic [7:0] I_MEM_RDATA,
    // clock enables
    output logic O_CPU_CLK_EN,
    output logic O_PERI_CLK_EN,
    output logic O_MAIN_OSC_EN,
    // memory strobe and read data
    output logic O_CS_B,
    output logic O_READ_STROBE,
    output logic [7:0] O_RDATA,
    output logic O_BUS_DONE,
    // interrupts
    output logic O_PERIODIC_REQ,
    output logic [1:0] O_PERIODIC_PRIO,
    output logic O_IRQ
);
    // main divisor in clock ticks, halved by the doubler [R1] [R2]
    function automatic logic [4:0] main_div(input logic [2:0] sel, input logic dbl,
                                            input logic peri);
        logic [4:0] osc_div;
        osc_div = 5'h08;
        case (sel)
            SEL_FULL: osc_div = 5'h01;
            SEL_DIV2: osc_div = 5'h02;
            SEL_DIV4: osc_div = 5'h04;
            SEL_DIV6: osc_div = 5'h06;
            SEL_CPU8_PER1: osc_div = peri ? 5'h01 : 5'h08;
            default: osc_div = 5'h08;
        endcase
        return dbl ? osc_div : 5'(osc_div << 1);
    endfunction

    // 32 kHz divider codes; reserved codes run undivided [R3] [R15]
    function automatic logic [4:0] slow_div(input logic [2:0] code);
        logic [4:0] d;
        d = 5'h01;
        case (code)
            3'h4: d = 5'h02;
            3'h5: d = 5'h04;
            3'h6: d = 5'h08;
            3'h7: d = 5'h10;
            default: d = 5'h01;
        endcase
        return d;
    endfunction

    // registers
    logic [1:0] stat_reg, stat_next;
    logic [2:0] sel_reg, sel_next;
    logic [1:0] prio_reg, prio_next;
    logic [7:0] psc_reg, psc_next;
    logic [3:0] dbl_reg, dbl_next;
    logic [2:0] irq_stat_reg, irq_stat_next;
    logic [2:0] irq_mask_reg, irq_mask_next;
    logic pend_reg, pend_next;
    // bus slave
    logic wr_pend_reg, wr_pend_next;
    logic [7:0] wr_idx_reg, wr_idx_next;
    logic [31:0] rdata_reg, rdata_next;
    // clocks and transaction
    logic clk32_d_reg;
    bus_state_t state_reg, state_next;
    logic tx_write_reg, tx_write_next;
    logic cs_b_reg, cs_b_next;
    logic [3:0] st_cnt_reg, st_cnt_next;
    logic st_fired_reg, st_fired_next;
    logic rd_strobe_reg, rd_strobe_next;
    logic done_reg, done_next;
    logic [7:0] mem_data_reg, mem_data_next;

    logic addr_ok, rd_acc, wr_acc;
    logic [7:0] acc_idx;
    logic slow_mode, cpu_tick, cpu_pulse, peri_pulse;
    logic [4:0] cpu_div, peri_div, cpu_left;
    logic [4:0] left_next;
    logic short_sel, selft_sel, in_tx;
    logic [3:0] selft_len;
    logic [2:0] irq_events;
    logic force_wr;

    assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;
    assign acc_idx = I_HADDR[9:2];
    assign rd_acc = addr_ok && !I_HWRITE && (I_HADDR[31:10] == 22'h000000);
    assign wr_acc = addr_ok && I_HWRITE && (I_HADDR[31:10] == 22'h000000);

    // clock enables; 32 kHz modes count slow clock edges [R14] [R3]
    assign slow_mode = (sel_reg == SEL_SLOW_OSC_ON) || (sel_reg == SEL_SLOW_OSC_OFF);
    assign cpu_tick = slow_mode ? (I_CLK32K && !clk32_d_reg) : 1'b1;
    assign cpu_div = slow_mode ? slow_div(psc_reg[PSC_DIV32_LSB +: 3])
                               : main_div(sel_reg, dbl_reg != 4'h0, 1'b0);
    assign peri_div = slow_mode ? cpu_div : main_div(sel_reg, dbl_reg != 4'h0, 1'b1);

    clk_period_divider u_cpu_div (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_tick(cpu_tick),
        .i_div(cpu_div),
        .o_pulse(cpu_pulse),
        .o_left(cpu_left)
    );

    clk_period_divider u_peri_div (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_tick(cpu_tick),
        .i_div(peri_div),
        .o_pulse(peri_pulse),
        .o_left()
    );

    // strobe shaping choices
    assign short_sel = (sel_reg != SEL_FULL) &&
        (tx_write_next ? psc_reg[PSC_SHORT_WR_BIT] : psc_reg[PSC_SHORT_RD_BIT]); // [R4] [R5] [R16] [R17]
    assign selft_sel = slow_mode && psc_reg[PSC_SELFT_LSB + 2]; // [R10]
    assign in_tx = (state_reg != ST_IDLE);
    // ticks left in the processor period during the next cycle
    assign left_next = cpu_pulse ? cpu_div : (cpu_tick ? cpu_left - 5'h01 : cpu_left);

    always_comb begin
        case (psc_reg[PSC_SELFT_LSB +: 2]) // [R18]
            2'h0: selft_len = SELFT_CYC_100;
            2'h1: selft_len = SELFT_CYC_101;
            2'h2: selft_len = SELFT_CYC_110;
            default: selft_len = SELFT_CYC_111;
        endcase
    end

    // bus transaction sequencer
    always_comb begin
        state_next = state_reg;
        tx_write_next = tx_write_reg;
        rd_strobe_next = 1'b0;
        done_next = 1'b0;
        mem_data_next = mem_data_reg;
        if (cpu_pulse) begin
            case (state_reg)
                ST_IDLE: begin
                    if (I_BUS_REQ) begin
                        state_next = ST_FIRST;
                        tx_write_next = I_BUS_WRITE;
                    end
                end
                ST_FIRST: state_next = I_BUS_WAIT ? ST_WAIT : ST_SECOND; // [R8]
                ST_WAIT: state_next = I_BUS_WAIT ? ST_WAIT : ST_SECOND; // [R8]
                ST_SECOND: begin
                    state_next = ST_IDLE;
                    done_next = 1'b1;
                    if (!tx_write_reg) begin
                        mem_data_next = I_MEM_RDATA; // [R7]
                        rd_strobe_next = 1'b1;
                    end
                end
                default: state_next = ST_IDLE;
            endcase
        end
    end

    // chip select: normal, short at the end, or self-timed
    always_comb begin
        st_cnt_next = (st_cnt_reg != 4'h0) ? st_cnt_reg - 4'h1 : 4'h0;
        st_fired_next = in_tx ? st_fired_reg : 1'b0;
        if (selft_sel && state_reg == ST_SECOND && cpu_left == SLOW_CS_TICKS && !st_fired_reg) begin
            st_cnt_next = selft_len; // [R10] [R18]
            st_fired_next = 1'b1;
        end
        // decided from the next state, so the registered strobe has no lag
        if (state_next == ST_IDLE) begin
            cs_b_next = 1'b1;
        end else if (selft_sel) begin
            cs_b_next = (st_cnt_reg == 4'h0);
        end else if (short_sel) begin
            cs_b_next = !((state_next == ST_SECOND) &&
                (left_next <= (slow_mode ? SLOW_CS_TICKS : SHORT_CS_TICKS))); // [R6] [R9]
        end else begin
            cs_b_next = 1'b0;
        end
    end

    // register writes, read side effects and events
    assign force_wr = wr_pend_reg && (wr_idx_reg == IDX_GLOBAL_CONTROL_STATUS) &&
                      I_HWDATA[GCS_FORCE_BIT];
    assign irq_events = {done_next, force_wr || I_PERIODIC_TICK, I_WDT_TIMEOUT};

    always_comb begin
        sel_next = sel_reg;
        prio_next = prio_reg;
        psc_next = psc_reg;
        dbl_next = dbl_reg;
        irq_mask_next = irq_mask_reg;
        irq_stat_next = irq_stat_reg;
        stat_next = stat_reg;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                IDX_GLOBAL_CONTROL_STATUS: begin
                    sel_next = I_HWDATA[GCS_SEL_LSB +: 3]; // [R14]
                    prio_next = I_HWDATA[GCS_PRIO_LSB +: 2]; // [R13]
                end
                IDX_POWER_SAVE_CONTROL: psc_next = I_HWDATA[7:0];
                IDX_CLOCK_DOUBLER: dbl_next = I_HWDATA[3:0];
                IDX_IRQ_STATUS: irq_stat_next = irq_stat_reg & ~I_HWDATA[2:0];
                IDX_IRQ_MASK: irq_mask_next = I_HWDATA[2:0];
                default: ;
            endcase
        end
        irq_stat_next = irq_stat_next | irq_events;
        // a read clears the field, but a same-cycle timeout still lands unless the field held STAT_RESET [R11]
        if (rd_acc && acc_idx == IDX_GLOBAL_CONTROL_STATUS) begin
            stat_next = STAT_NONE;
        end
        if (I_WDT_TIMEOUT && stat_reg != STAT_RESET) begin
            stat_next = STAT_WATCHDOG; // [R11]
        end
        pend_next = force_wr || I_PERIODIC_TICK || (pend_reg && !I_PERIODIC_ACK); // [R12]
    end

    // ahb-lite slave: zero wait states, read data latched at address phase
    always_comb begin
        wr_pend_next = wr_acc;
        wr_idx_next = wr_acc ? acc_idx : wr_idx_reg;
        rdata_next = rdata_reg;
        if (rd_acc) begin
            case (acc_idx)
                IDX_GLOBAL_CONTROL_STATUS: rdata_next = {24'h000000, stat_reg, 1'b0,
                                                         sel_reg, prio_reg}; // [R12]
                IDX_POWER_SAVE_CONTROL: rdata_next = {24'h000000, psc_reg};
                IDX_CLOCK_DOUBLER: rdata_next = {28'h0000000, dbl_reg};
                IDX_IRQ_STATUS: rdata_next = {29'h00000000, irq_stat_reg};
                IDX_IRQ_MASK: rdata_next = {29'h00000000, irq_mask_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            stat_reg <= STAT_RESET;
            sel_reg <= SEL_RESET;
            prio_reg <= PRIO_RESET;
            psc_reg <= PSC_RESET;
            dbl_reg <= DBL_RESET;
            irq_stat_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
            pend_reg <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 8'h00;
            rdata_reg <= 32'h00000000;
            clk32_d_reg <= 1'b0;
            state_reg <= ST_IDLE;
            tx_write_reg <= 1'b0;
            cs_b_reg <= 1'b1;
            st_cnt_reg <= 4'h0;
            st_fired_reg <= 1'b0;
            rd_strobe_reg <= 1'b0;
            done_reg <= 1'b0;
            mem_data_reg <= 8'h00;
        end else begin
            stat_reg <= stat_next;
            sel_reg <= sel_next;
            prio_reg <= prio_next;
            psc_reg <= psc_next;
            dbl_reg <= dbl_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            pend_reg <= pend_next;
            wr_pend_reg <= wr_pend_next;
            wr_idx_reg <= wr_idx_next;
            rdata_reg <= rdata_next;
            clk32_d_reg <= I_CLK32K;
            state_reg <= state_next;
            tx_write_reg <= tx_write_next;
            cs_b_reg <= cs_b_next;
            st_cnt_reg <= st_cnt_next;
            st_fired_reg <= st_fired_next;
            rd_strobe_reg <= rd_strobe_next;
            done_reg <= done_next;
            mem_data_reg <= mem_data_next;
        end
    end

    assign O_HRDATA = rdata_reg;
    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign O_CPU_CLK_EN = cpu_pulse;
    assign O_PERI_CLK_EN = peri_pulse;
    assign O_MAIN_OSC_EN = (sel_reg != SEL_SLOW_OSC_OFF);
    assign O_CS_B = cs_b_reg;
    assign O_READ_STROBE = rd_strobe_reg;
    assign O_RDATA = mem_data_reg;
    assign O_BUS_DONE = done_reg;
    assign O_PERIODIC_REQ = pend_reg && (prio_reg != 2'h0); // [R13]
    assign O_PERIODIC_PRIO = prio_reg;
    assign O_IRQ = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

/* bench/mem_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mem_model #(
    parameter logic [7:0] DATA_BYTE = 8'h3C
) (
    // strobe from the controller
    input wire logic i_cs_b,
    // byte back to the controller
    output logic [7:0] o_rdata
);
    // unselected, the bus shows the inverse so a stale capture is caught
    assign o_rdata = i_cs_b ? ~DATA_BYTE : DATA_BYTE;
endmodule
`default_nettype wire

/* bench/lp_clock_ctrl_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module lp_clock_ctrl_assertions (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_B,
    // watched ports
    input wire logic O_HREADYOUT,
    input wire logic O_HRESP,
    input wire logic O_READ_STROBE,
    input wire logic O_BUS_DONE,
    input wire logic [7:0] O_RDATA,
    input wire logic [7:0] I_MEM_RDATA,
    input wire logic O_CPU_CLK_EN,
    input wire logic O_CS_B,
    input wire logic O_PERIODIC_REQ,
    input wire logic [1:0] O_PERIODIC_PRIO,
    input wire logic I_PERIODIC_TICK
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_B);
    property p_bus_okay;
        O_HREADYOUT && !O_HRESP;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not okay with zero wait");
    property p_capture;
        O_READ_STROBE |-> O_RDATA == $past(I_MEM_RDATA);
    endproperty
    a_capture: assert property (p_capture)
        else $error("read data not taken at end of second state");
    property p_strobe_done;
        O_READ_STROBE |-> O_BUS_DONE;
    endproperty
    a_strobe_done: assert property (p_strobe_done)
        else $error("read strobe without transaction end");
    property p_done_edge;
        O_BUS_DONE |-> $past(O_CPU_CLK_EN);
    endproperty
    a_done_edge: assert property (p_done_edge)
        else $error("transaction end off a processor clock boundary");
    property p_done_cs;
        O_BUS_DONE |-> O_CS_B ##1 (O_CS_B && !O_BUS_DONE);
    endproperty
    a_done_cs: assert property (p_done_cs)
        else $error("select not released at transaction end");
    property p_cs_inside;
        $fell(O_CS_B) |-> !O_BUS_DONE ##[1:1000] O_BUS_DONE;
    endproperty
    a_cs_inside: assert property (p_cs_inside)
        else $error("select pulse not closed by a transaction end");
    property p_req_prio;
        O_PERIODIC_REQ |-> O_PERIODIC_PRIO != 2'h0;
    endproperty
    a_req_prio: assert property (p_req_prio)
        else $error("periodic request while disabled");
    property p_tick_req;
        I_PERIODIC_TICK && O_PERIODIC_PRIO != 2'h0 |=> O_PERIODIC_REQ;
    endproperty
    a_tick_req: assert property (p_tick_req)
        else $error("periodic tick not made pending");
endmodule
bind lp_clock_ctrl lp_clock_ctrl_assertions lp_clock_ctrl_assertions_i (.*);
`default_nettype wire

/* bench/lp_clock_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module lp_clock_ctrl_tb;
    import lp_clock_pkg::*;
    localparam int SLOW_HALF = 10;
    localparam logic [7:0] MEM_BYTE = 8'h3C;
    localparam logic [2:0] SEL_TAB [6] = '{SEL_CPU8_PER8, SEL_CPU8_PER1, SEL_FULL,
        SEL_DIV2, SEL_DIV4, SEL_DIV6};
    localparam int CPU_TAB [6] = '{16, 16, 2, 4, 8, 12};
    localparam logic [2:0] DIV_TAB [4] = '{3'h0, 3'h4, 3'h7, 3'h1};
    localparam int DIV_N [4] = '{1, 2, 16, 1};
    localparam int ST_TAB [4] = '{12, 10, 7, 5};
    logic I_CLK = 1'b0, I_RST_B = 1'b0, I_HSEL = 1'b0, I_HWRITE = 1'b0, I_CLK32K = 1'b0;
    logic [31:0] I_HADDR = 32'h0, I_HWDATA = 32'h0, O_HRDATA, rd;
    logic [1:0] I_HTRANS = 2'h0, O_PERIODIC_PRIO;
    logic [2:0] I_HSIZE = 3'h2, ev = 3'h0;
    logic I_BUS_REQ = 1'b0, I_BUS_WRITE = 1'b0, I_BUS_WAIT = 1'b0;
    logic O_HREADYOUT, O_HRESP, O_CPU_CLK_EN, O_PERI_CLK_EN, O_MAIN_OSC_EN, O_CS_B;
    logic O_READ_STROBE, O_BUS_DONE, O_PERIODIC_REQ, O_IRQ;
    logic [7:0] I_MEM_RDATA, O_RDATA;
    wire logic I_HREADY = O_HREADYOUT;
    wire logic I_WDT_TIMEOUT = ev[0];
    wire logic I_PERIODIC_TICK = ev[1];
    wire logic I_PERIODIC_ACK = ev[2];
    int mismatches = 0;
    int n_tests = 0;
    int n;
    always #12.5 I_CLK = ~I_CLK;
    // slow clock shortened to keep the run brief
    always #(SLOW_HALF * 25) I_CLK32K = ~I_CLK32K;
    lp_clock_ctrl lp_clock_ctrl_i (.*);
    mem_model #(.DATA_BYTE(MEM_BYTE)) mem_model_i (.i_cs_b(O_CS_B), .o_rdata(I_MEM_RDATA));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        @(posedge I_CLK);
        I_HSEL <= 1'b1;
        I_HTRANS <= 2'h2;
        I_HWRITE <= w;
        I_HADDR <= {22'h0, idx, 2'h0};
        do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
        I_HTRANS <= 2'h0;
        I_HWDATA <= d;
        do @(posedge I_CLK); while (O_HREADYOUT !== 1'b1);
        rd = O_HRDATA;
        @(negedge I_CLK);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        ahb(1'b1, idx, d);
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        ahb(1'b0, idx, 32'h0);
        check("register read", rd, exp);
    endtask
    task automatic sel(input logic [2:0] s);
        wr(IDX_GLOBAL_CONTROL_STATUS, {27'h0, s, 2'h0});
    endtask
    task automatic ev_pulse(input int b);
        @(posedge I_CLK);
        ev[b] <= 1'b1;
        @(posedge I_CLK);
        ev[b] <= 1'b0;
        @(negedge I_CLK);
    endtask
    // the second interval is the first one wholly under the new divisor
    task automatic period(input logic peri, output int cnt);
        repeat (3) begin
            cnt = 0;
            do begin
                @(negedge I_CLK);
                cnt++;
            end while ((peri ? O_PERI_CLK_EN : O_CPU_CLK_EN) !== 1'b1 && cnt < 2000);
        end
    endtask
    // wait held over the first boundary gives exactly one wait state
    task automatic xfer(input logic w, input logic wt, input int exp_low, input logic [7:0] q);
        int low;
        int pulses;
        low = 0;
        pulses = 0;
        @(posedge I_CLK);
        I_BUS_REQ <= 1'b1;
        I_BUS_WRITE <= w;
        I_BUS_WAIT <= wt;
        do begin
            @(negedge I_CLK);
            low += int'(O_CS_B === 1'b0);
            pulses += int'(O_CPU_CLK_EN === 1'b1);
            if (pulses == 2 && O_CPU_CLK_EN === 1'b1) begin
                @(posedge I_CLK);
                I_BUS_REQ <= 1'b0;
                I_BUS_WAIT <= 1'b0;
            end
        end while (O_BUS_DONE !== 1'b1);
        check("select low cycles", low, exp_low);
        if (!w) begin
            check("read byte", O_RDATA, q);
        end
    endtask
    initial begin
        repeat (60000) @(posedge I_CLK);
        mismatches++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge I_CLK);
        I_RST_B <= 1'b1;
        rdchk(IDX_GLOBAL_CONTROL_STATUS, 32'hC0);
        rdchk(IDX_GLOBAL_CONTROL_STATUS, 32'h00);
        for (int d = 0; d < 2; d++) begin
            wr(IDX_CLOCK_DOUBLER, 32'(d));
            for (int m = 0; m < 6; m++) begin
                sel(SEL_TAB[m]);
                period(1'b0, n);
                check("cpu period", n, CPU_TAB[m] >> d);
                period(1'b1, n);
                check("peri period", n, (m == 1 ? 2 : CPU_TAB[m]) >> d);
            end
        end
        wr(IDX_CLOCK_DOUBLER, 32'h0);
        sel(SEL_FULL);
        wr(IDX_POWER_SAVE_CONTROL, 32'h10);
        xfer(1'b0, 1'b1, 6, MEM_BYTE);
        sel(SEL_DIV2);
        xfer(1'b0, 1'b1, 4, MEM_BYTE);
        xfer(1'b1, 1'b1, 12, 8'h0);
        wr(IDX_POWER_SAVE_CONTROL, 32'h08);
        xfer(1'b1, 1'b0, 4, 8'h0);
        xfer(1'b0, 1'b0, 8, MEM_BYTE);
        sel(SEL_SLOW_OSC_ON);
        check("osc enable", O_MAIN_OSC_EN, 1'b1);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_POWER_SAVE_CONTROL, {29'h0, DIV_TAB[k]});
            for (int p = 0; p < 2; p++) begin
                period(p[0], n);
                check("slow period", n, DIV_N[k] * 2 * SLOW_HALF);
            end
        end
        sel(SEL_SLOW_OSC_OFF);
        check("osc enable", O_MAIN_OSC_EN, 1'b0);
        wr(IDX_POWER_SAVE_CONTROL, 32'h14);
        xfer(1'b0, 1'b0, 2 * SLOW_HALF, MEM_BYTE);
        for (int k = 0; k < 4; k++) begin
            wr(IDX_POWER_SAVE_CONTROL, {24'h000000, 3'(4 + k), 5'h04});
            xfer(1'b1, 1'b0, ST_TAB[k], 8'h0);
        end
        sel(SEL_DIV2);
        ev_pulse(0);
        wr(IDX_GLOBAL_CONTROL_STATUS, 32'h2E);
        check("periodic", {O_PERIODIC_REQ, O_PERIODIC_PRIO}, 3'h6);
        rdchk(IDX_GLOBAL_CONTROL_STATUS, 32'h4E);
        ev_pulse(2);
        for (int p = 0; p < 4; p++) begin
            wr(IDX_GLOBAL_CONTROL_STATUS, 32'h0C | p);
            ev_pulse(1);
            check("periodic", {O_PERIODIC_REQ, O_PERIODIC_PRIO}, {p != 0, 2'(p)});
            ev_pulse(2);
        end
        rdchk(IDX_IRQ_STATUS, 32'h7);
        check("irq", O_IRQ, 1'b0);
        wr(IDX_IRQ_MASK, 32'h2);
        check("irq", O_IRQ, 1'b1);
        wr(IDX_IRQ_STATUS, 32'h2);
        check("irq", O_IRQ, 1'b0);
        rdchk(IDX_IRQ_STATUS, 32'h5);
        rdchk(8'h20, 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
